// [src/cchp_pkg.sv]
// Shared constants, types and helpers for the counter channel block
package cchp_pkg;

  localparam int         CCHP_NCH     = 4;
  localparam int         CCHP_NZC     = 3;

  // Control word bit positions
  localparam int         CW_IE        = 7;
  localparam int         CW_MODE      = 6;
  localparam int         CW_PRE       = 5;
  localparam int         CW_EDGE      = 4;
  localparam int         CW_TRIG      = 3;
  localparam int         CW_TC        = 2;
  localparam int         CW_SRST      = 1;
  localparam int         CW_CTRL      = 0;

  // Vector field layout
  localparam int         VEC_HI_LSB   = 3;

  // Values after reset
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] TC_RST       = 8'h00;
  localparam logic [7:0] CNT_RST      = 8'h00;
  localparam logic [4:0] VEC_HI_RST   = 5'h00;

  // Counter value whose next decrement is the zero count, which reloads the constant
  localparam logic [7:0] CNT_LAST     = 8'h01;

  // Prescaler terminal masks, divide by 16 or 256
  localparam logic [7:0] PRE_MASK_16  = 8'h0f;
  localparam logic [7:0] PRE_MASK_256 = 8'hff;

  // Two-byte return-from-interrupt opcode
  localparam logic [7:0] RETURN_FROM_IRQ_OP_PREFIX  = 8'hed;
  localparam logic [7:0] RETURN_FROM_IRQ_OP_OP      = 8'h4d;

  typedef enum logic {
    RETURN_FROM_IRQ_OP_IDLE,
    RETURN_FROM_IRQ_OP_SEEN_PREFIX
  } cchp_return_from_irq_op_t;

  // Index of the lowest set bit; channel 0 has top priority
  function automatic logic [1:0] cchp_first_set(input logic [3:0] v);
    logic [1:0] idx;
    idx = 2'h3;
    for (int i = CCHP_NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

endpackage

// [src/cchp_edge_det.sv]
// Per-channel active edge detector for the external edge inputs
`timescale 1ns/1ns
module cchp_edge_det
  import cchp_pkg::*;
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // Edge inputs and polarity, 1 selects rising
  input  wire logic [CCHP_NCH-1:0] sig,
  input  wire logic [CCHP_NCH-1:0] rise_sel,
  // One pulse per active edge
  output logic      [CCHP_NCH-1:0] hit
);

  logic [CCHP_NCH-1:0] prev_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prev_r <= '0;
    end else begin
      prev_r <= sig;
    end
  end

  // An edge landing just before a clock edge acts at that edge; sig reaches hit with no synchronizer stage
  always_comb begin
    for (int i = 0; i < CCHP_NCH; i++) begin
      hit[i] = rise_sel[i] ? (sig[i] & ~prev_r[i]) : (~sig[i] & prev_r[i]);
    end
  end

endmodule

// [src/cchp_irq_prio.sv]
// Fixed-priority interrupt arbiter across the four channels
`timescale 1ns/1ns
module cchp_irq_prio
  import cchp_pkg::*;
(
  // Pending and in-service flags
  input  wire logic [CCHP_NCH-1:0] pend,
  input  wire logic [CCHP_NCH-1:0] in_svc,
  // Winning channel
  output logic                     grant_vld,
  output logic      [1:0]          grant_ch
);

  logic [1:0] svc_top;

  always_comb begin
    grant_ch  = cchp_first_set(pend);
    svc_top   = cchp_first_set(in_svc);
    // A channel under service blocks itself and all below it
    grant_vld = |pend && (~|in_svc || (grant_ch < svc_top));
  end

endmodule

// [src/cchp_top.sv]
// Four-channel counter block with host bus, daisy chain and vectors
`timescale 1ns/1ns
module cchp_top
  import cchp_pkg::*;
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // Host data bus, split into its three signals
  input  wire logic [7:0]          data_in,
  output logic      [7:0]          data_out,
  output logic                     data_oe,
  // Host cycle control
  input  wire logic                chan_sel_lo,
  input  wire logic                chan_sel_hi,
  input  wire logic                chip_sel_n,
  input  wire logic                io_request_n,
  input  wire logic                read_n,
  input  wire logic                opcode_fetch_cycle_n,
  // Daisy chain
  input  wire logic                chain_enable_in,
  output logic                     chain_enable_out,
  // Open-drain interrupt request
  output logic                     irq_n_out,
  output logic                     irq_oe,
  // Channel pins
  input  wire logic [CCHP_NCH-1:0] ext_edge_in,
  output logic      [CCHP_NZC-1:0] zero_reached_pulse
);

  logic [1:0]          sel;
  logic                wr_act;
  logic                rd_act;
  logic                ack_act;
  logic                fetch_act;
  logic                wr_prev_r;
  logic                ack_prev_r;
  logic                fetch_prev_r;
  logic                wr_go;
  logic                ack_go;
  logic                ack_take;
  logic                fetch_end;
  logic [CCHP_NCH-1:0] wr_ch;
  logic [7:0]          ctrl_r [CCHP_NCH];
  logic [7:0]          tc_r   [CCHP_NCH];
  logic [7:0]          cnt_r  [CCHP_NCH];
  logic [7:0]          pre_r  [CCHP_NCH];
  logic [CCHP_NCH-1:0] run_r;
  logic [CCHP_NCH-1:0] arm_r;
  logic [CCHP_NCH-1:0] tc_pend_r;
  logic [CCHP_NCH-1:0] ip_r;
  logic [CCHP_NCH-1:0] ius_r;
  logic [CCHP_NCH-1:0] rise_sel;
  logic [CCHP_NCH-1:0] edge_hit;
  logic [CCHP_NCH-1:0] tick;
  logic [CCHP_NCH-1:0] dec;
  logic [CCHP_NCH-1:0] zero_ev;
  logic [CCHP_NCH-1:0] ip_set;
  logic [CCHP_NCH-1:0] ip_clr;
  logic [CCHP_NCH-1:0] ius_set;
  logic [CCHP_NCH-1:0] ius_clr;
  logic [4:0]          vec_hi_r;
  logic [1:0]          ack_ch_r;
  logic                ack_drv_r;
  logic                grant_vld;
  logic [1:0]          grant_ch;
  logic [7:0]          op_r;
  cchp_return_from_irq_op_t          return_from_irq_op_r;
  cchp_return_from_irq_op_t          return_from_irq_op_nxt;
  logic                return_from_irq_op_go;
  logic [7:0]          sel_cnt;

  // Host cycle decode
  always_comb begin
    sel       = {chan_sel_hi, chan_sel_lo};
    wr_act    = !io_request_n && !chip_sel_n && read_n &&
                opcode_fetch_cycle_n;
    rd_act    = !io_request_n && !chip_sel_n && !read_n &&
                opcode_fetch_cycle_n;
    ack_act   = !io_request_n && !opcode_fetch_cycle_n;
    fetch_act = io_request_n && !opcode_fetch_cycle_n && !read_n;
    wr_go     = wr_act && !wr_prev_r;
    ack_go    = ack_act && !ack_prev_r;
    fetch_end = fetch_prev_r && !fetch_act;
    ack_take  = ack_go && chain_enable_in && grant_vld;
    sel_cnt   = cnt_r[sel];
    for (int i = 0; i < CCHP_NCH; i++) begin
      wr_ch[i] = wr_go && (sel == 2'(i));
    end
  end

  // Write and acknowledge cycles act once, on their first clock; fetches act at their end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_prev_r    <= 1'b0;
      ack_prev_r   <= 1'b0;
      fetch_prev_r <= 1'b0;
    end else begin
      wr_prev_r    <= wr_act;
      ack_prev_r   <= ack_act;
      fetch_prev_r <= fetch_act;
    end
  end

  always_comb begin
    for (int i = 0; i < CCHP_NCH; i++) begin
      rise_sel[i] = ctrl_r[i][CW_EDGE];
    end
  end

  cchp_edge_det u_edge (
    .clock    (clock),
    .rst_n    (rst_n),
    .sig      (ext_edge_in),
    .rise_sel (rise_sel),
    .hit      (edge_hit)
  );

  // Count source per channel
  always_comb begin
    for (int i = 0; i < CCHP_NCH; i++) begin
      if (ctrl_r[i][CW_MODE]) begin
        tick[i] = edge_hit[i];
      end else begin
        tick[i] = ctrl_r[i][CW_PRE] ?
                  (pre_r[i] == PRE_MASK_256) :
                  ((pre_r[i] & PRE_MASK_16) == PRE_MASK_16);
      end
      dec[i]     = run_r[i] && tick[i];
      zero_ev[i] = dec[i] && (cnt_r[i] == CNT_LAST);
    end
  end

  // Timer prescalers run only while a timer channel is running
  always_ff @(posedge clock) begin
    for (int i = 0; i < CCHP_NCH; i++) begin
      if (!rst_n || !run_r[i] || ctrl_r[i][CW_MODE]) begin
        pre_r[i] <= '0;
      end else begin
        pre_r[i] <= pre_r[i] + 8'h01;
      end
    end
  end

  // Channel programming and down-counting
  always_ff @(posedge clock) begin
    for (int i = 0; i < CCHP_NCH; i++) begin
      if (!rst_n) begin
        ctrl_r[i]    <= CTRL_RST;
        tc_r[i]      <= TC_RST;
        cnt_r[i]     <= CNT_RST;
        run_r[i]     <= 1'b0;
        arm_r[i]     <= 1'b0;
        tc_pend_r[i] <= 1'b0;
      end else begin
        if (zero_ev[i]) begin
          cnt_r[i] <= tc_r[i];
        end else if (dec[i]) begin
          cnt_r[i] <= cnt_r[i] - 8'h01;
        end
        if (arm_r[i] && edge_hit[i]) begin
          arm_r[i] <= 1'b0;
          run_r[i] <= 1'b1;
        end
        if (wr_ch[i] && tc_pend_r[i]) begin
          tc_r[i]      <= data_in;
          tc_pend_r[i] <= 1'b0;
          if (!run_r[i]) begin
            cnt_r[i] <= data_in;
            if (ctrl_r[i][CW_MODE] || !ctrl_r[i][CW_TRIG]) begin
              run_r[i] <= 1'b1;
            end else begin
              arm_r[i] <= 1'b1;
            end
          end else if (zero_ev[i]) begin
            cnt_r[i] <= data_in;
          end
        end else if (wr_ch[i] && data_in[CW_CTRL]) begin
          ctrl_r[i]    <= data_in;
          tc_pend_r[i] <= data_in[CW_TC];
          if (data_in[CW_SRST]) begin
            run_r[i] <= 1'b0;
            arm_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  // Vector base shared by all channels
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vec_hi_r <= VEC_HI_RST;
    end else if (wr_go && !tc_pend_r[sel] && !data_in[CW_CTRL]) begin
      vec_hi_r <= data_in[7:VEC_HI_LSB];
    end
  end

  cchp_irq_prio u_prio (
    .pend      (ip_r),
    .in_svc    (ius_r),
    .grant_vld (grant_vld),
    .grant_ch  (grant_ch)
  );

  // Return-from-interrupt watch on opcode fetches
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      op_r <= '0;
    end else if (fetch_act) begin
      op_r <= data_in;
    end
  end

  always_comb begin
    return_from_irq_op_nxt = return_from_irq_op_r;
    return_from_irq_op_go  = 1'b0;
    if (fetch_end) begin
      case (return_from_irq_op_r)
        RETURN_FROM_IRQ_OP_IDLE: begin
          if (op_r == RETURN_FROM_IRQ_OP_PREFIX) begin
            return_from_irq_op_nxt = RETURN_FROM_IRQ_OP_SEEN_PREFIX;
          end
        end
        RETURN_FROM_IRQ_OP_SEEN_PREFIX: begin
          return_from_irq_op_go  = (op_r == RETURN_FROM_IRQ_OP_OP);
          return_from_irq_op_nxt = (op_r == RETURN_FROM_IRQ_OP_PREFIX) ? RETURN_FROM_IRQ_OP_SEEN_PREFIX : RETURN_FROM_IRQ_OP_IDLE;
        end
        default: begin
          return_from_irq_op_nxt = RETURN_FROM_IRQ_OP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      return_from_irq_op_r <= RETURN_FROM_IRQ_OP_IDLE;
    end else begin
      return_from_irq_op_r <= return_from_irq_op_nxt;
    end
  end

  // Pending and in-service flags; a set beats a same-cycle clear
  always_comb begin
    for (int i = 0; i < CCHP_NCH; i++) begin
      ip_set[i]  = zero_ev[i] && ctrl_r[i][CW_IE];
      ip_clr[i]  = ack_take && (grant_ch == 2'(i));
      ius_set[i] = ip_clr[i];
      ius_clr[i] = return_from_irq_op_go && (cchp_first_set(ius_r) == 2'(i));
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ip_r  <= '0;
      ius_r <= '0;
    end else begin
      ip_r  <= (ip_r & ~ip_clr) | ip_set;
      ius_r <= (ius_r & ~ius_clr) | ius_set;
    end
  end

  // Acknowledge bookkeeping
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_drv_r <= 1'b0;
      ack_ch_r  <= '0;
    end else if (ack_take) begin
      ack_drv_r <= 1'b1;
      ack_ch_r  <= grant_ch;
    end else if (!ack_act) begin
      ack_drv_r <= 1'b0;
    end
  end

  // Data bus driver; registered so the pin never glitches mid-cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_out <= '0;
      data_oe  <= 1'b0;
    end else if (ack_take) begin
      data_out <= {vec_hi_r, grant_ch, 1'b0};
      data_oe  <= 1'b1;
    end else if (ack_act && ack_drv_r) begin
      data_oe  <= 1'b1;
    end else if (rd_act) begin
      data_out <= sel_cnt;
      data_oe  <= 1'b1;
    end else begin
      data_oe  <= 1'b0;
    end
  end

  // Pin outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      zero_reached_pulse <= '0;
    end else begin
      zero_reached_pulse <= zero_ev[CCHP_NZC-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      chain_enable_out <= chain_enable_in;
    end else begin
      chain_enable_out <= chain_enable_in && ~|ius_r;
    end
  end

  // Open drain: only ever pulls low, enable carries the request
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_n_out <= 1'b0;
      irq_oe    <= 1'b0;
    end else begin
      irq_n_out <= 1'b0;
      irq_oe    <= grant_vld && chain_enable_in;
    end
  end

  // Checks
  sequence s_zero0;
    dec[0] && cnt_r[0] == CNT_LAST;
  endsequence

  sequence s_zero2;
    dec[2] && cnt_r[2] == CNT_LAST;
  endsequence

  sequence s_fetch_return_from_irq_op;
    fetch_end && return_from_irq_op_r == RETURN_FROM_IRQ_OP_SEEN_PREFIX && op_r == RETURN_FROM_IRQ_OP_OP;
  endsequence

  property p_zero_reload;
    @(posedge clock) disable iff (!rst_n)
    s_zero0 |=> zero_reached_pulse[0] && cnt_r[0] == $past(tc_r[0]);
  endproperty
  a_zero_reload: assert property (p_zero_reload)
    else $error("zero count did not pulse and reload");

  property p_pulse_one;
    @(posedge clock) disable iff (!rst_n)
    zero_reached_pulse[1] |-> $past(zero_ev[1]) ##1
      !zero_reached_pulse[1];
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("zero pulse not one clock wide");

  property p_reset_quiet;
    @(posedge clock)
    !rst_n |=> !data_oe && !irq_oe && zero_reached_pulse == '0 &&
      run_r == '0 && !ctrl_r[0][CW_IE] && !ctrl_r[3][CW_IE];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("reset left outputs or enables active");

  property p_chain_block;
    @(posedge clock) disable iff (!rst_n)
    |ius_r |=> !chain_enable_out;
  endproperty
  a_chain_block: assert property (p_chain_block)
    else $error("chain output high during service");

  property p_read_data;
    @(posedge clock) disable iff (!rst_n)
    rd_act && !ack_act |=> data_oe && data_out == $past(sel_cnt);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read cycle did not return the count");

  property p_idle_release;
    @(posedge clock) disable iff (!rst_n)
    chip_sel_n && opcode_fetch_cycle_n |=> !data_oe;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("bus driven without chip select");

  property p_vector;
    @(posedge clock) disable iff (!rst_n)
    ack_take |=> data_oe && data_out[0] == 1'b0 &&
      data_out[2:1] == ack_ch_r && ius_r[ack_ch_r];
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector layout or service flag wrong");

  property p_irq_req;
    @(posedge clock) disable iff (!rst_n)
    s_zero2 ##0 ctrl_r[2][CW_IE] && ~|ius_r && chain_enable_in &&
      !ack_act |=> ip_r[2] ##1 irq_oe;
  endproperty
  a_irq_req: assert property (p_irq_req)
    else $error("enabled zero count raised no request");

  property p_ctrl_load;
    @(posedge clock) disable iff (!rst_n)
    wr_ch[0] && !tc_pend_r[0] && data_in[CW_CTRL] |=>
      ctrl_r[0] == $past(data_in);
  endproperty
  a_ctrl_load: assert property (p_ctrl_load)
    else $error("control word not loaded");

  property p_tc_defer;
    @(posedge clock) disable iff (!rst_n)
    wr_ch[0] && tc_pend_r[0] && run_r[0] && !zero_ev[0] |=>
      cnt_r[0] == ($past(dec[0]) ? $past(cnt_r[0]) - 8'h01 :
                   $past(cnt_r[0]));
  endproperty
  a_tc_defer: assert property (p_tc_defer)
    else $error("new time constant loaded mid count");

  property p_return_from_irq_op_clear;
    @(posedge clock) disable iff (!rst_n)
    s_fetch_return_from_irq_op ##0 (|ius_r) && !ack_take |=>
      $countones(ius_r) == $countones($past(ius_r)) - 1;
  endproperty
  a_return_from_irq_op_clear: assert property (p_return_from_irq_op_clear)
    else $error("return opcode did not end service");

endmodule

// [test/cchp_host.sv]
// Host processor bus model driving the block's cycle pins
`timescale 1ns/1ns
module cchp_host (
  // Clock
  input  wire logic       clock,
  // Device side of the data bus
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic      [7:0] data_in,
  // Cycle control
  output logic            chan_sel_lo,
  output logic            chan_sel_hi,
  output logic            chip_sel_n,
  output logic            io_request_n,
  output logic            read_n,
  output logic            opcode_fetch_cycle_n
);
  logic [7:0] drv_val;
  logic       drv_on;
  logic [7:0] last_r = 8'h00;

  // Floating bus shows inverse of last level, never a stale copy
  assign data_in = data_oe ? data_out : drv_on ? drv_val : ~last_r;
  always @(posedge clock) last_r <= data_in;

  initial begin
    {chan_sel_hi, chan_sel_lo} = 2'h0;
    drv_val = 8'h00;
    idle_set();
  end

  task automatic idle_set();
    {chip_sel_n, io_request_n, read_n, opcode_fetch_cycle_n} = 4'hf;
    drv_on = 1'b0;
  endtask

  // Held one edge only, then released for a cycle
  task automatic wr(input logic [1:0] ch, input logic [7:0] v,
                    input logic cs_n);
    @(negedge clock);
    {chan_sel_hi, chan_sel_lo} = ch;
    chip_sel_n = cs_n;
    drv_val = v;
    drv_on = 1'b1;
    io_request_n = 1'b0;
    @(negedge clock);
    idle_set();
  endtask

  task automatic rd(input logic [1:0] ch, input logic cs_n,
                    output logic [7:0] v, output logic oe);
    @(negedge clock);
    {chan_sel_hi, chan_sel_lo} = ch;
    chip_sel_n = cs_n;
    read_n = 1'b0;
    io_request_n = 1'b0;
    repeat (2) @(negedge clock);
    v = data_in;
    oe = data_oe;
    idle_set();
  endtask

  task automatic ack(output logic [7:0] v, output logic oe);
    @(negedge clock);
    opcode_fetch_cycle_n = 1'b0;
    io_request_n = 1'b0;
    repeat (2) @(negedge clock);
    v = data_in;
    oe = data_oe;
    idle_set();
  endtask

  // Two opcode fetches; the block snoops the bus for the pair
  task automatic return_from_irq_op();
    for (int i = 0; i < 2; i++) begin
      @(negedge clock);
      drv_val = (i == 0) ? 8'hed : 8'h4d;
      drv_on = 1'b1;
      opcode_fetch_cycle_n = 1'b0;
      read_n = 1'b0;
      repeat (2) @(negedge clock);
      idle_set();
    end
  endtask
endmodule

// [test/cchp_top_tb.sv]
// Self-checking bench for the counter channel block
`timescale 1ns/1ns
module cchp_top_tb;
  logic       clock = 1'b0;
  logic       rst_n;
  logic       chain_enable_in;
  logic [3:0] ext_edge_in;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic       data_oe;
  logic       sel_lo;
  logic       sel_hi;
  logic       cs_n;
  logic       io_request_n_n;
  logic       rd_n;
  logic       fetch_n;
  logic       chain_enable_out;
  logic       irq_n_out;
  logic       irq_oe;
  logic [2:0] zero_reached_pulse;
  int         errors = 0;
  int         samples_checked = 0;
  int         zc[3] = '{0, 0, 0};
  logic [7:0] v;
  logic       oe;

  always #4 clock = ~clock;

  cchp_top i_cchp_top (.clock(clock), .rst_n(rst_n), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .chan_sel_lo(sel_lo),
    .chan_sel_hi(sel_hi), .chip_sel_n(cs_n), .io_request_n(io_request_n_n),
    .read_n(rd_n), .opcode_fetch_cycle_n(fetch_n),
    .chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out),
    .irq_n_out(irq_n_out), .irq_oe(irq_oe), .ext_edge_in(ext_edge_in),
    .zero_reached_pulse(zero_reached_pulse));

  cchp_host i_cchp_host (.clock(clock), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in), .chan_sel_lo(sel_lo),
    .chan_sel_hi(sel_hi), .chip_sel_n(cs_n), .io_request_n(io_request_n_n),
    .read_n(rd_n), .opcode_fetch_cycle_n(fetch_n));

  // Sampled mid-cycle so the pulse is never read at its launching edge
  always @(negedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (zero_reached_pulse[i] === 1'b1) zc[i]++;
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic quiet();
    chk("chain_out", chain_enable_in, chain_enable_out);
    chk("data_oe", 8'h0, data_oe);
    chk("irq_oe", 8'h0, irq_oe);
    chk("zero_pulse", 8'h0, zero_reached_pulse);
  endtask

  task automatic pulse(input int ch, input logic lvl);
    @(negedge clock);
    ext_edge_in[ch] = lvl;
    repeat (3) @(negedge clock);
  endtask

  task automatic prog(input logic [1:0] ch, input logic [7:0] cw,
                      input logic [7:0] tc);
    i_cchp_host.wr(ch, cw, 1'b0);
    i_cchp_host.wr(ch, tc, 1'b0);
  endtask

  task automatic rc(input logic [1:0] ch, input logic [7:0] e);
    i_cchp_host.rd(ch, 1'b0, v, oe);
    chk("read_oe", 8'h1, oe);
    chk("count", e, v);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_oe !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    chk("irq_oe", 8'h1, irq_oe);
    chk("irq_n_out", 8'h0, irq_n_out);
    if (n == 20) test_done();
  endtask

  // Each channel keeps its own constant; ignored cycles change nothing
  task automatic t_select();
    for (int i = 0; i < 4; i++) prog(2'(i), 8'h45, 8'(8'h10 + i));
    for (int i = 0; i < 4; i++) rc(2'(i), 8'(8'h10 + i));
    i_cchp_host.wr(2'h0, 8'h45, 1'b1);
    i_cchp_host.wr(2'h0, 8'h33, 1'b1);
    i_cchp_host.rd(2'h0, 1'b1, v, oe);
    chk("read_oe_cs", 8'h0, oe);
    rc(2'h0, 8'h10);
  endtask

  task automatic t_count();
    prog(2'h0, 8'h57, 8'h03);
    rc(2'h0, 8'h03);
    pulse(0, 1'b1);
    pulse(0, 1'b0);
    rc(2'h0, 8'h02);
    pulse(1, 1'b1);
    rc(2'h1, 8'h11);
    pulse(1, 1'b0);
    rc(2'h1, 8'h10);
    prog(2'h0, 8'h55, 8'h05);
    rc(2'h0, 8'h02);
    for (int i = 0; i < 2; i++) begin
      pulse(0, 1'b1);
      pulse(0, 1'b0);
    end
    chk("zero_cycles", 8'h1, 8'(zc[0]));
    rc(2'h0, 8'h05);
    chk("irq_off", 8'h0, irq_oe);
  endtask

  task automatic t_irq();
    i_cchp_host.wr(2'h3, 8'ha8, 1'b0);
    prog(2'h1, 8'hd7, 8'h01);
    prog(2'h2, 8'hd7, 8'h01);
    chain_enable_in = 1'b0;
    pulse(1, 1'b1);
    pulse(2, 1'b1);
    i_cchp_host.ack(v, oe);
    chk("ack_blocked", 8'h0, oe);
    chain_enable_in = 1'b1;
    wait_irq();
    i_cchp_host.ack(v, oe);
    chk("ack_oe", 8'h1, oe);
    chk("vector", 8'haa, v);
    @(negedge clock);
    chk("chain_busy", 8'h0, chain_enable_out);
    i_cchp_host.return_from_irq_op();
    repeat (4) @(negedge clock);
    chk("chain_free", 8'h1, chain_enable_out);
    wait_irq();
    i_cchp_host.ack(v, oe);
    chk("vector2", 8'hac, v);
    i_cchp_host.return_from_irq_op();
  endtask

  // Timer on channel 3 holds until its trigger edge, then prescales by 16
  task automatic t_timer();
    prog(2'h3, 8'h0f, 8'h02);
    repeat (20) @(negedge clock);
    rc(2'h3, 8'h02);
    pulse(3, 1'b1);
    pulse(3, 1'b0);
    repeat (17) @(negedge clock);
    rc(2'h3, 8'h01);
  endtask

  // Reset with a request outstanding must silence it and stop counting
  task automatic t_reset_mid();
    prog(2'h2, 8'hd5, 8'h01);
    pulse(2, 1'b0);
    pulse(2, 1'b1);
    wait_irq();
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    quiet();
    rst_n = 1'b1;
    pulse(2, 1'b0);
    pulse(2, 1'b1);
    rc(2'h2, 8'h00);
    chk("irq_after", 8'h0, irq_oe);
  endtask

  initial begin
    rst_n = 1'b0;
    chain_enable_in = 1'b0;
    ext_edge_in = 4'h0;
    repeat (8) @(negedge clock);
    quiet();
    chain_enable_in = 1'b1;
    repeat (8) @(negedge clock);
    quiet();
    rst_n = 1'b1;
    t_select();
    t_count();
    t_timer();
    t_irq();
    t_reset_mid();
    test_done();
  end
endmodule
